// >>> rtl/sar_device.sv
// Converter device end: mode select, conversion timing and serial output
// Contract
// R01 - Chain input high at start: select mode
// R02 - Chain input low at start: daisy chain
// R03 - Result is unsigned straight binary, 16 bits
// R04 - Internal clock times conversion, serial clock shifts
// R05 - 3-wire start edge: tri-state, sample, convert
// R06 - Host restores start before min, holds to max
// R07 - After conversion: acquire, power down, keep result
// R08 - Host waits max conversion before selecting
// R09 - 3-wire start fall drives MSB, then falls
// R10 - 3-wire output off after 16th fall or rise
// R11 - Host captures on either serial clock edge
// R12 - 4-wire: start stays high until read done
// R13 - 4-wire select back high during conversion window
// R14 - 4-wire select fall drives MSB, off after 16
// R15 - Several 4-wire devices: select after previous done
// R16 - 4-wire: never both start and select low
// R17 - Output driven low when both inputs low
// R18 - Chain: serial clock low at start edge
// R19 - Chain: load result, drive MSB at end
// R20 - Chain: each fall shifts chain input in
// R21 - Host issues 16 times N falls for chain
// R22 - Chain wiring: first input low, clocks shared
// R23 - Host takes bit before 3 ns hold ends
// R24 - Host counts max conversion time itself
`timescale 1ns/1ps
`default_nettype none
module sar_device (
  input wire logic CLK,
  input wire logic RESET_N,
  sar_link_if.device LINK,
  input wire logic [15:0] SAMPLE_IN,
  output logic [15:0] RESULT,
  output logic BUSY,
  output logic [1:0] MODE
);
  logic cs_s, ck_s, di_s;
  logic cs_d, ck_d, di_d;
  logic cs_rise, cs_fall, ck_fall, di_fall, di_rise;
  logic [15:0] held;
  logic [15:0] shreg;
  logic [4:0] bits;
  logic [sar_pkg::CNT_W-1:0] conv_cnt;
  logic dout_o, dout_oe;
  sar_pkg::sar_mode_t mode;
  // Decoded events, shared by the acquisition flag, output and status processes
  logic idle;
  logic eoc;
  logic both_low;
  logic sel_4w;
  logic acq;

  sar_sync u_cs (.CLK(CLK), .RESET_N(RESET_N), .d(LINK.convert_start), .q(cs_s));
  sar_sync u_ck (.CLK(CLK), .RESET_N(RESET_N), .d(LINK.sclk), .q(ck_s));
  sar_sync #(.INIT(1'b1)) u_di (.CLK(CLK), .RESET_N(RESET_N), .d(LINK.din), .q(di_s));

  // Edge detection on synchronised pins
  // Delays reset to each pin's idle level, so reset alone makes no edge
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_d <= 1'b0;
      ck_d <= 1'b0;
      di_d <= 1'b1; // Idles high
    end else begin
      cs_d <= cs_s;
      ck_d <= ck_s;
      di_d <= di_s;
    end
  end
  assign cs_rise = cs_s & ~cs_d;
  assign cs_fall = ~cs_s & cs_d;
  assign ck_fall = ~ck_s & ck_d;
  assign di_fall = ~di_s & di_d;
  assign di_rise = di_s & ~di_d;

  // Acquisition phase: no conversion running, result may be read out
  assign idle = (conv_cnt == '0);
  // Last counted cycle of a conversion
  assign eoc = (conv_cnt == sar_pkg::CNT_W'(1));
  // Both inputs low parks the output low, so a chain link never floats
  assign both_low = ~cs_s & ~di_s;
  // Chain input falling under a high start is a 4-wire select; a 3-wire
  // host ties that input high, so the same test serves before relabelling
  assign sel_4w = cs_s & di_fall & (mode != sar_pkg::SAR_MODE_CHAIN);

  // Mode latched at start edge; 4-wire told apart by select low while start high later
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode <= sar_pkg::SAR_MODE_3W;
    end else if (cs_rise) begin
      if (di_s) begin
        mode <= sar_pkg::SAR_MODE_3W; // R01
      end else begin
        mode <= sar_pkg::SAR_MODE_CHAIN; // R02
      end
    end else if (mode == sar_pkg::SAR_MODE_3W && conv_cnt == '0 && cs_s && di_fall) begin
      mode <= sar_pkg::SAR_MODE_4W; // R01
    end
  end

  // Conversion timed by own counter; serial clock plays no part
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      conv_cnt <= '0;
      held <= sar_pkg::RESULT_RESET;
    end else if (cs_rise) begin
      conv_cnt <= sar_pkg::CNT_W'(sar_pkg::CONV_MODEL_CYC); // R04 R05
      held <= SAMPLE_IN; // R03
    end else if (conv_cnt != '0) begin
      conv_cnt <= conv_cnt - 1'b1; // R04
    end
  end

  // Acquisition flag: the converter core is powered down while it is high;
  // only the digital shift path toggles during readout
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acq <= 1'b1;
    end else if (cs_rise) begin
      acq <= 1'b0; // R05
    end else if (eoc) begin
      acq <= 1'b1; // R07
    end
  end

  // Shift register for all modes; bit count for the 3-wire and 4-wire reads only
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      shreg <= sar_pkg::RESULT_RESET;
      bits <= 5'h00;
      dout_oe <= 1'b0;
      dout_o <= 1'b0;
    end else if (cs_rise) begin
      dout_oe <= (di_s == 1'b0); // R05 R17
      dout_o <= 1'b0;
      bits <= 5'h00;
    end else if (eoc) begin
      // End of conversion: result kept for readout while idle
      shreg <= held; // R07
      bits <= 5'h00;
      if (mode == sar_pkg::SAR_MODE_CHAIN) begin
        dout_oe <= 1'b1; // R19
        dout_o <= held[15]; // R19
      end
    end else if (idle) begin
      if (both_low) begin
        // Parked low ahead of a chain start; never seen during a read
        dout_oe <= 1'b1; // R17
        dout_o <= 1'b0; // R17
      end else if (mode == sar_pkg::SAR_MODE_CHAIN) begin
        if (ck_fall) begin
          shreg <= {shreg[14:0], di_s}; // R20
          dout_o <= shreg[14]; // R20
        end
      end else if (mode == sar_pkg::SAR_MODE_3W && cs_fall) begin
        // 3-wire: start falling selects and brings out the MSB
        dout_oe <= 1'b1; // R09
        dout_o <= shreg[15]; // R09
        bits <= 5'h01;
      end else if (sel_4w) begin
        // 4-wire: select falling brings out the MSB, same cycle as relabelling
        dout_oe <= 1'b1; // R14
        dout_o <= shreg[15]; // R14
        bits <= 5'h01;
      end else if (mode == sar_pkg::SAR_MODE_4W && di_rise) begin
        dout_oe <= 1'b0; // R14
      end else if (dout_oe && ck_fall) begin
        // The 16th fall releases the line; a select rise does so earlier
        if (bits == 5'h10) begin
          dout_oe <= 1'b0; // R10 R14
        end else begin
          dout_o <= shreg[4'(15 - bits)]; // R09
          bits <= bits + 1'b1;
          if (bits == 5'h0f) begin
            bits <= 5'h10;
          end
        end
      end
    end else if (!cs_s && !di_s) begin
      // Both low during a conversion: park low as well
      dout_oe <= 1'b1; // R17
      dout_o <= 1'b0; // R17
    end
  end

  // Status outputs straight from flops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESULT <= sar_pkg::RESULT_RESET;
      BUSY <= 1'b0;
      MODE <= 2'h0;
    end else begin
      // Reloads only at end of conversion, so a chain read-out leaves it intact
      if (eoc) begin
        RESULT <= held; // R07
      end
      BUSY <= ~acq; // R04
      MODE <= mode;
    end
  end

  assign LINK.dout_o = dout_o;
  assign LINK.dout_oe = dout_oe;
endmodule
`default_nettype wire

// >>> rtl/sar_pkg.sv
// Package: shared constants and types for the serial readout converter link
package sar_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CONV_MIN_NS = 500;
  localparam int unsigned CONV_MAX_NS = 8800;
  // Least time rounds up, longest time rounds down
  localparam int unsigned CONV_MIN_CYC = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  // Model conversion time inside the device, between min and max
  localparam int unsigned CONV_MODEL_CYC = CONV_MIN_CYC + 20;
  localparam int unsigned CNT_W = 10;
  localparam logic [9:0] CONV_MAX_CNT = 10'h160;
  // Host serial clock half period in system cycles, less one (4 cycles, 200 ns period)
  localparam logic [1:0] SCLK_HALF = 2'h3;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  typedef enum logic [1:0] {SAR_MODE_3W, SAR_MODE_4W, SAR_MODE_CHAIN} sar_mode_t;
endpackage

// >>> rtl/sar_link_if.sv
// Interface: pins between converter device and host controller
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
  logic convert_start;
  logic sclk;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic dout;
  // Line level resolved here; pulled high when undriven
  assign dout = dout_oe ? dout_o : 1'b1;
  modport device (input convert_start, input sclk, input din, output dout_o, output dout_oe);
  modport host (output convert_start, output sclk, output din, input dout);
endinterface
`default_nettype wire

// >>> rtl/sar_sync.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module sar_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic d,
  output logic q
);
  logic meta;
  // First stage is read by the second only; reset to the pin's idle level
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/sar_host.sv
// Host controller end: starts conversions, waits, clocks out a result
`timescale 1ns/1ps
`default_nettype none
module sar_host (
  input wire logic CLK,
  input wire logic RESET_N,
  sar_link_if.host LINK,
  input wire logic START,
  input wire logic [1:0] MODE_SEL,
  output logic [15:0] DATA,
  output logic DONE,
  output logic BUSY
);
  typedef enum logic [2:0] {
    SH_IDLE, SH_PULSE, SH_WAIT, SH_SEL, SH_SHIFT, SH_END, SH_REL
  } sar_host_state_t;
  sar_host_state_t state;
  logic [9:0] wait_cnt;
  logic [1:0] div;
  logic [4:0] nbits;
  logic sclk, cnv, din;
  logic dout_s;
  logic [1:0] mode;

  sar_sync #(.INIT(1'b1)) u_do (.CLK(CLK), .RESET_N(RESET_N), .d(LINK.dout), .q(dout_s));

  // Sequencer; serial clock is a divided copy of CLK
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= SH_IDLE;
      wait_cnt <= 10'h000;
      div <= 2'h0;
      nbits <= 5'h00;
      sclk <= 1'b0;
      cnv <= 1'b0;
      din <= 1'b1;
      DATA <= 16'h0000;
      DONE <= 1'b0;
      BUSY <= 1'b0;
      mode <= 2'h0;
    end else begin
      DONE <= 1'b0;
      case (state)
        SH_IDLE: begin
          sclk <= 1'b0; // R18
          if (START) begin
            mode <= MODE_SEL;
            din <= (MODE_SEL != 2'h2); // R01 R02 R22
            BUSY <= 1'b1;
            state <= SH_PULSE;
          end
        end
        SH_PULSE: begin
          cnv <= 1'b1;
          wait_cnt <= sar_pkg::CONV_MAX_CNT; // R24
          state <= SH_WAIT;
        end
        SH_WAIT: begin
          // Convert-start stays high across the whole window; select does too, except in chain mode where it is held low
          if (wait_cnt != 10'h000) begin
            wait_cnt <= wait_cnt - 1'b1; // R06 R08 R13
          end else begin
            state <= SH_SEL;
          end
        end
        SH_SEL: begin
          if (mode == 2'h0) begin
            cnv <= 1'b0; // R08
          end else if (mode == 2'h1) begin
            din <= 1'b0; // R12 R16
          end
          nbits <= 5'h00;
          div <= 2'h0;
          state <= SH_SHIFT;
        end
        SH_SHIFT: begin
          div <= div + 1'b1;
          if (div == sar_pkg::SCLK_HALF) begin
            div <= 2'h0;
            if (nbits == 5'h10) begin
              state <= SH_END; // R21
            end else begin
              sclk <= ~sclk;
              if (sclk) begin
                // Capture at the fall: the synchronised line still holds the
                // bit that this fall is about to replace
                DATA <= {DATA[14:0], dout_s}; // R11 R23
                nbits <= nbits + 1'b1;
              end
            end
          end
        end
        SH_END: begin
          // Select goes high first, start drops a cycle later
          din <= 1'b1; // R15 R16
          state <= SH_REL;
        end
        SH_REL: begin
          cnv <= 1'b0; // R12 R18
          DONE <= 1'b1;
          BUSY <= 1'b0;
          state <= SH_IDLE;
        end
        default: state <= SH_IDLE;
      endcase
    end
  end

  assign LINK.sclk = sclk;
  assign LINK.convert_start = cnv;
  assign LINK.din = din;
endmodule
`default_nettype wire

// >>> tb/sar_link_sva.sv
// Checker: pin timing on the link between converter and host
`timescale 1ns/1ps
`default_nettype none
module sar_link_sva (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic convert_start,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe
);
  logic cs_mode;
  logic cnv_q;
  logic sclk_q;
  int conv_cnt;
  int fcnt;
  int since_fall;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Mode, time since start and falls since start, restarted at each start edge
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_mode <= 1'b0;
      cnv_q <= 1'b0;
      conv_cnt <= 0;
      fcnt <= 0;
    end else begin
      cnv_q <= convert_start;
      if (convert_start && !cnv_q) begin
        cs_mode <= din;
        conv_cnt <= 1;
        fcnt <= 0;
      end else begin
        // Saturate so a long idle cannot wrap
        if (conv_cnt < 1000) conv_cnt <= conv_cnt + 1;
        if (sclk_q && !sclk) fcnt <= fcnt + 1;
      end
    end
  end
  // Cycles since the last serial clock fall
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_q <= 1'b0;
      since_fall <= 100;
    end else begin
      sclk_q <= sclk;
      if (sclk_q && !sclk) since_fall <= 0;
      else if (since_fall < 100) since_fall <= since_fall + 1;
    end
  end
  property p_tri_start;
    $rose(convert_start) && din |-> ##[1:5] !dout_oe;
  endproperty
  a_tri_start: assert property (p_tri_start) else $error("output not off at start");
  property p_sel_drive;
    cs_mode && fcnt == 0 && (($fell(convert_start) && din) || (convert_start && $fell(din)))
      |-> ##[1:5] dout_oe;
  endproperty
  a_sel_drive: assert property (p_sel_drive) else $error("output not on at select");
  property p_shift;
    cs_mode && dout_oe && $past(dout_oe) && $changed(dout_o) |-> since_fall <= 5;
  endproperty
  a_shift: assert property (p_shift) else $error("bit changed without clock fall");
  property p_off16;
    cs_mode && fcnt == 16 |-> ##[0:5] !dout_oe;
  endproperty
  a_off16: assert property (p_off16) else $error("output on after last fall");
  property p_off_din;
    cs_mode && convert_start && $rose(din) |-> ##[1:5] !dout_oe;
  endproperty
  a_off_din: assert property (p_off_din) else $error("output on after deselect");
  property p_chain_load;
    $rose(convert_start) && !din |-> ##[1:400] dout_oe;
  endproperty
  a_chain_load: assert property (p_chain_load) else $error("chain result not driven");
  property p_wait_max;
    cs_mode && fcnt == 0 && (($fell(convert_start) && din) || (convert_start && $fell(din)))
      |-> conv_cnt >= sar_pkg::CONV_MAX_CYC;
  endproperty
  a_wait_max: assert property (p_wait_max) else $error("select before max time");
  property p_clk_low;
    $rose(convert_start) && !din |-> !sclk;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("serial clock high at start");
  property p_not_both;
    cs_mode && fcnt < 16 |-> convert_start || din;
  endproperty
  a_not_both: assert property (p_not_both) else $error("start and select both low");
  property p_both_low;
    !convert_start && !din |-> ##[1:5] dout_oe && !dout_o;
  endproperty
  a_both_low: assert property (p_both_low) else $error("output not parked low");
  property p_chain_hold;
    !cs_mode && $fell(convert_start) |-> fcnt == 16;
  endproperty
  a_chain_hold: assert property (p_chain_hold) else $error("start dropped early");
endmodule
`default_nettype wire

// >>> tb/sar_adc_serial_readout_bench.sv
// Testbench: host and converter joined over the link, reads in every mode
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_bench;
  logic clk;
  logic reset_n;
  logic start;
  logic [1:0] mode_sel;
  logic [15:0] sample;
  logic [15:0] result;
  logic [15:0] data;
  logic done;
  logic dev_busy;
  logic host_busy;
  logic [1:0] dev_mode;
  int err_total;
  int checks;
  // Back-to-back reads, boundary codes, mode switches both ways
  logic [1:0] modes [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  logic [15:0] values [5] = '{16'hffff, 16'h0000, 16'ha5c3, 16'h5a3c, 16'h8001};
  sar_link_if link();
  sar_device i_sar_device (.CLK(clk), .RESET_N(reset_n), .LINK(link), .SAMPLE_IN(sample),
    .RESULT(result), .BUSY(dev_busy), .MODE(dev_mode));
  sar_host i_sar_host (.CLK(clk), .RESET_N(reset_n), .LINK(link), .START(start),
    .MODE_SEL(mode_sel), .DATA(data), .DONE(done), .BUSY(host_busy));
  sar_link_sva i_sar_link_sva (.CLK(clk), .RESET_N(reset_n),
    .convert_start(link.convert_start), .sclk(link.sclk), .din(link.din),
    .dout_o(link.dout_o), .dout_oe(link.dout_oe));
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One transaction: start, wait for the done pulse, compare the word
  task automatic read_one(input logic [1:0] mode, input logic [15:0] value);
    int n;
    sample <= value;
    mode_sel <= mode;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check("device busy", 16'h0001, {15'h0000, dev_busy});
    check("host busy", 16'h0001, {15'h0000, host_busy});
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("done seen", 16'h0001, {15'h0000, done});
    check("host idle", 16'h0000, {15'h0000, host_busy});
    check("data", value, data);
    check("result", value, result);
    check("mode", {14'h0000, mode}, {14'h0000, dev_mode});
    check("device idle", 16'h0000, {15'h0000, dev_busy});
    repeat (10) @(posedge clk);
    #1;
    // Released line reads the pull-up level only if the device let go
    if (mode != 2'h2) check("line off", 16'h0001, {15'h0000, link.dout});
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Five reads take near 2500 cycles; this allows over three times that
  initial begin
    #200000;
    err_total++;
    close_out();
  end
  initial begin
    reset_n = 1'b0;
    start = 1'b0;
    mode_sel = 2'h0;
    sample = 16'h0000;
    err_total = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("idle pins", 16'h0001, {13'h0000, link.convert_start, link.sclk, link.din});
    @(posedge clk);
    for (int i = 0; i < 5; i++) read_one(modes[i], values[i]);
    close_out();
  end
endmodule
`default_nettype wire
